// ==== hw/window_comparator_alert_status.sv ====
`timescale 1ns/1ns
module window_comparator_alert_status
  import wcmp_pkg::*;
(
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire wcmp_pkg::axil_req_t    axil_req,
  output wcmp_pkg::axil_rsp_t         axil_rsp,
  input  wire wcmp_pkg::conv_sample_t conv,
  input  wire logic                   busy,
  input  wire logic                   gc_reset,
  output logic                        alert,
  output logic                        seq_go_pulse,
  output logic                        irq
);
  import wcmp_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  axil_rsp_t         rsp_r,       rsp_nxt;
  logic [ADDR_W-1:0] awaddr_r,    awaddr_nxt;
  logic [DATA_W-1:0] wdata_r,     wdata_nxt;
  logic [3:0]        wstrb_r,     wstrb_nxt;
  logic              aw_have_r,   aw_have_nxt;
  logic              w_have_r,    w_have_nxt;
  logic [HYS_W-1:0]  hys_r [NCH];
  logic [HYS_W-1:0]  hys_nxt [NCH];
  thresh_t           thr_r [NCH];
  thresh_t           thr_nxt [NCH];
  logic [CNT_W-1:0]  evcnt_r,     evcnt_nxt;
  logic [3:0]        chid_r,      chid_nxt;
  logic              chid_done_r, chid_done_nxt;
  logic [NCH-1:0]    under_r,     under_nxt;
  logic [NCH-1:0]    over_r,      over_nxt;
  logic [IRQ_W-1:0]  irq_stat_r,  irq_stat_nxt;
  logic [IRQ_W-1:0]  irq_mask_r,  irq_mask_nxt;
  logic              alert_r,     alert_nxt;
  logic              irq_r,       irq_nxt;
  logic              seq_go_r,    seq_go_nxt;
  logic [NCH-1:0]    under_hit;
  logic [NCH-1:0]    over_hit;
  logic              wr_fire;
  logic              rd_fire;
  logic [IDX_W-1:0]  wr_idx;
  logic [IDX_W-1:0]  rd_idx;
  logic [DATA_W-1:0] byte_mask;
  logic [DATA_W-1:0] rd_word;
  logic              rd_ok;
  logic              wr_ok;

  // ----------------------------------------------------------------
  // Per-channel comparators
  // ----------------------------------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < NCH; ch++) begin : g_chan
      wcmp_channel u_chan (
        .aclk         (aclk),
        .aresetn      (aresetn),
        .restart      (gc_reset),
        .sample_valid (conv.valid && (conv.chan == 1'(ch))),
        .result       (conv.result),
        .thresh       (thr_r[ch]),
        .hyst         (hys_r[ch]),
        .event_count  (evcnt_r),
        .under_hit    (under_hit[ch]),
        .over_hit     (over_hit[ch])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // Write commits once both address and data are held and no response is pending
  assign wr_fire   = aw_have_r && w_have_r && !rsp_r.bvalid;
  assign rd_fire   = axil_req.arvalid && rsp_r.arready;
  assign wr_idx    = awaddr_r[ADDR_W-1:2];
  assign rd_idx    = axil_req.araddr[ADDR_W-1:2];
  assign byte_mask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};

  always_comb begin
    rd_word = '0;
    rd_ok   = 1'b1;
    unique case (rd_idx)
      IDX_FIRST_CHAN: rd_word[CHID_LSB +: 4] = chid_r;
      IDX_UNDER:      rd_word[NCH-1:0] = under_r;
      IDX_OVER:       rd_word[NCH-1:0] = over_r;
      IDX_EVCNT:      rd_word[EVCNT_LSB +: CNT_W] = evcnt_r;
      IDX_HYS0:       rd_word[HYS_W-1:0] = hys_r[0];
      IDX_HYS1:       rd_word[HYS_W-1:0] = hys_r[1];
      IDX_THR0:       rd_word = {4'h0, thr_r[0].high, 4'h0, thr_r[0].low};
      IDX_THR1:       rd_word = {4'h0, thr_r[1].high, 4'h0, thr_r[1].low};
      IDX_STATUS:     rd_word[0] = busy;
      IDX_IRQ_STAT:   rd_word[IRQ_W-1:0] = irq_stat_r;
      IDX_IRQ_MASK:   rd_word[IRQ_W-1:0] = irq_mask_r;
      default:        rd_ok = 1'b0;
    endcase
  end

  always_comb begin
    unique case (wr_idx)
      IDX_UNDER, IDX_OVER, IDX_EVCNT, IDX_HYS0, IDX_HYS1, IDX_THR0, IDX_THR1,
      IDX_CTRL, IDX_IRQ_MASK, IDX_FIRST_CHAN, IDX_STATUS, IDX_IRQ_STAT: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic [NCH-1:0] under_clr;
    logic [NCH-1:0] over_clr;
    logic [IRQ_W-1:0] irq_clr;
    logic [DATA_W-1:0] thr_word;
    under_clr     = '0;
    over_clr      = '0;
    irq_clr       = '0;
    thr_word      = '0;
    rsp_nxt       = rsp_r;
    awaddr_nxt    = awaddr_r;
    wdata_nxt     = wdata_r;
    wstrb_nxt     = wstrb_r;
    aw_have_nxt   = aw_have_r;
    w_have_nxt    = w_have_r;
    hys_nxt       = hys_r;
    thr_nxt       = thr_r;
    evcnt_nxt     = evcnt_r;
    irq_mask_nxt  = irq_mask_r;
    seq_go_nxt    = 1'b0;
    // Write address and data are taken in either order
    if (axil_req.awvalid && rsp_r.awready) begin
      awaddr_nxt  = axil_req.awaddr;
      aw_have_nxt = 1'b1;
    end
    if (axil_req.wvalid && rsp_r.wready) begin
      wdata_nxt  = axil_req.wdata;
      wstrb_nxt  = axil_req.wstrb;
      w_have_nxt = 1'b1;
    end
    if (wr_fire) begin
      rsp_nxt.bvalid = 1'b1;
      rsp_nxt.bresp  = wr_ok ? RESP_OKAY : RESP_SLVERR;
      if (wstrb_r[0]) begin
        unique case (wr_idx)
          IDX_UNDER:    under_clr = wdata_r[NCH-1:0];
          IDX_OVER:     over_clr  = wdata_r[NCH-1:0];
          IDX_EVCNT:    evcnt_nxt = wdata_r[EVCNT_LSB +: CNT_W];
          IDX_HYS0:     hys_nxt[0] = wdata_r[HYS_W-1:0];
          IDX_HYS1:     hys_nxt[1] = wdata_r[HYS_W-1:0];
          IDX_CTRL:     seq_go_nxt = wdata_r[CTRL_SEQ_BIT];
          IDX_IRQ_MASK: irq_mask_nxt = wdata_r[IRQ_W-1:0];
          default:      ;
        endcase
      end
      for (int i = 0; i < NCH; i++) begin
        if (wr_idx == (IDX_THR0 + IDX_W'(i))) begin
          thr_word   = ({4'h0, thr_r[i].high, 4'h0, thr_r[i].low} & ~byte_mask) | (wdata_r & byte_mask);
          thr_nxt[i] = {thr_word[RES_W-1:0], thr_word[THR_HIGH_LSB +: RES_W]};
        end
      end
    end
    if (rsp_r.bvalid && axil_req.bready) begin
      rsp_nxt.bvalid = 1'b0;
      aw_have_nxt    = 1'b0;
      w_have_nxt     = 1'b0;
    end
    rsp_nxt.awready = !aw_have_nxt;
    rsp_nxt.wready  = !w_have_nxt;
    // Read answers one cycle after the address is taken
    if (rd_fire) begin
      rsp_nxt.arready = 1'b0;
      rsp_nxt.rvalid  = 1'b1;
      rsp_nxt.rdata   = rd_word;
      rsp_nxt.rresp   = rd_ok ? RESP_OKAY : RESP_SLVERR;
      if (rd_idx == IDX_IRQ_STAT) begin
        irq_clr = irq_stat_r;
      end
    end else if (rsp_r.rvalid && axil_req.rready) begin
      rsp_nxt.rvalid  = 1'b0;
      rsp_nxt.arready = 1'b1;
      rsp_nxt.rdata   = '0;
    end
    // Address channel reopens after reset as well as after each answer
    rsp_nxt.arready = !rsp_nxt.rvalid;
    // New hits win over any clear in the same cycle
    if (gc_reset) begin
      under_nxt = under_hit;
      over_nxt  = over_hit;
    end else begin
      under_nxt = (under_r & ~under_clr) | under_hit;
      over_nxt  = (over_r & ~over_clr) | over_hit;
    end
    irq_stat_nxt = (irq_stat_r & ~irq_clr);
    irq_stat_nxt[IRQ_UNDER_BIT] = irq_stat_nxt[IRQ_UNDER_BIT] | (|under_hit);
    irq_stat_nxt[IRQ_OVER_BIT]  = irq_stat_nxt[IRQ_OVER_BIT] | (|over_hit);
    // Channel 0 is named when both channels alert in the same cycle
    chid_nxt      = chid_r;
    chid_done_nxt = chid_done_r;
    if (gc_reset || seq_go_nxt) begin
      chid_nxt      = RST_CHID;
      chid_done_nxt = 1'b0;
    end else if (!chid_done_r && (|(under_hit | over_hit))) begin
      chid_nxt      = (under_hit[0] || over_hit[0]) ? CHID_CH0 : CHID_CH1;
      chid_done_nxt = 1'b1;
    end
    alert_nxt = |{under_nxt, over_nxt};
    irq_nxt   = |(irq_stat_nxt & irq_mask_nxt);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rsp_r       <= '0;
      awaddr_r    <= '0;
      wdata_r     <= '0;
      wstrb_r     <= '0;
      aw_have_r   <= 1'b0;
      w_have_r    <= 1'b0;
      for (int i = 0; i < NCH; i++) begin
        hys_r[i]      <= RST_HYS;
        thr_r[i].low  <= RST_THR_LOW;
        thr_r[i].high <= RST_THR_HIGH;
      end
      evcnt_r     <= RST_EVCNT;
      chid_r      <= RST_CHID;
      chid_done_r <= 1'b0;
      under_r     <= '0;
      over_r      <= '0;
      irq_stat_r  <= '0;
      irq_mask_r  <= RST_IRQ_MASK;
      alert_r     <= 1'b0;
      irq_r       <= 1'b0;
      seq_go_r    <= 1'b0;
    end else begin
      rsp_r       <= rsp_nxt;
      awaddr_r    <= awaddr_nxt;
      wdata_r     <= wdata_nxt;
      wstrb_r     <= wstrb_nxt;
      aw_have_r   <= aw_have_nxt;
      w_have_r    <= w_have_nxt;
      hys_r       <= hys_nxt;
      thr_r       <= thr_nxt;
      evcnt_r     <= evcnt_nxt;
      chid_r      <= chid_nxt;
      chid_done_r <= chid_done_nxt;
      under_r     <= under_nxt;
      over_r      <= over_nxt;
      irq_stat_r  <= irq_stat_nxt;
      irq_mask_r  <= irq_mask_nxt;
      alert_r     <= alert_nxt;
      irq_r       <= irq_nxt;
      seq_go_r    <= seq_go_nxt;
    end
  end

  assign axil_rsp     = rsp_r;
  assign alert        = alert_r;
  assign irq          = irq_r;
  assign seq_go_pulse = seq_go_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [IDX_W-1:0] rd_idx_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_idx_r <= '0;
    end else if (rd_fire) begin
      rd_idx_r <= rd_idx;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  hys_upper_zero_a: assert property ($rose(rsp_r.rvalid) && rd_idx_r == IDX_HYS1 |->
      rsp_r.rdata[DATA_W-1:HYS_W] == '0 && rsp_r.rdata[HYS_W-1:0] == hys_r[1])
    else $error("hysteresis upper bits not zero");
  evcnt_layout_a: assert property ($rose(rsp_r.rvalid) && rd_idx_r == IDX_EVCNT |->
      rsp_r.rdata[3:0] == 4'h0 && rsp_r.rdata[7:4] == evcnt_r)
    else $error("event count layout wrong");
  chid_code_a: assert property ($rose(rsp_r.rvalid) && rd_idx_r == IDX_FIRST_CHAN |->
      rsp_r.rdata[7:5] == 3'h0 && rsp_r.rdata[3:0] == 4'h0)
    else $error("illegal first channel code");
  seq_go_clear_a: assert property (wr_fire && wr_idx == IDX_CTRL && wstrb_r[0] && wdata_r[CTRL_SEQ_BIT]
      |=> chid_r == RST_CHID && seq_go_pulse ##1 !seq_go_pulse)
    else $error("sequence go did not clear first channel");
  w1c_single_a: assert property (wr_fire && wr_idx == IDX_UNDER && wstrb_r[0] && wdata_r[0] && !wdata_r[1]
      && !under_hit[0] && !gc_reset |=> !under_r[0] && under_r[1] == $past(under_r[1] | under_hit[1]))
    else $error("write one clear wrong");
  flag_sticky_a: assert property (over_r[1] && !gc_reset && !(wr_fire && wr_idx == IDX_OVER) |=> over_r[1])
    else $error("over flag lost");
  chid_hold_a: assert property (chid_done_r && !gc_reset && !seq_go_nxt |=> $stable(chid_r))
    else $error("first channel changed");
  alert_cause_a: assert property ($rose(alert) |-> $past(|(under_hit | over_hit)))
    else $error("alert without qualified hit");
  flag_upper_zero_a: assert property ($rose(rsp_r.rvalid) && (rd_idx_r == IDX_UNDER || rd_idx_r == IDX_OVER)
      |-> rsp_r.rdata[DATA_W-1:2] == '0)
    else $error("flag upper bits not zero");
  gc_clear_a: assert property (gc_reset && !(|(under_hit | over_hit)) |=> under_r == '0 && over_r == '0
      && chid_r == RST_CHID)
    else $error("general call did not clear");

  alert_seen_c: cover property ($rose(alert));
  chid_ch1_c: cover property (chid_done_r && chid_r == CHID_CH1);
  w1c_done_c: cover property ($fell(under_r[0]));
  irq_seen_c: cover property ($rose(irq));

endmodule

// ==== hw/wcmp_pkg.sv ====
package wcmp_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 9;
  localparam int DATA_W = 32;
  localparam int IDX_W  = ADDR_W - 2;
  localparam int RES_W  = 12;
  localparam int HYS_W  = 6;
  localparam int CNT_W  = 4;
  localparam int NCH    = 2;
  localparam int IRQ_W  = 2;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_FIRST_CHAN = 7'h03;
  localparam logic [IDX_W-1:0] IDX_UNDER      = 7'h0c;
  localparam logic [IDX_W-1:0] IDX_OVER       = 7'h0e;
  localparam logic [IDX_W-1:0] IDX_EVCNT      = 7'h36;
  localparam logic [IDX_W-1:0] IDX_HYS0       = 7'h40;
  localparam logic [IDX_W-1:0] IDX_HYS1       = 7'h41;
  localparam logic [IDX_W-1:0] IDX_THR0       = 7'h50;
  localparam logic [IDX_W-1:0] IDX_THR1       = 7'h51;
  localparam logic [IDX_W-1:0] IDX_CTRL       = 7'h52;
  localparam logic [IDX_W-1:0] IDX_STATUS     = 7'h53;
  localparam logic [IDX_W-1:0] IDX_IRQ_STAT   = 7'h60;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK   = 7'h61;

  // ----------------------------------------------------------------
  // Field positions and codes
  // ----------------------------------------------------------------
  localparam int EVCNT_LSB     = 4;
  localparam int CHID_LSB      = 4;
  localparam int THR_HIGH_LSB  = 16;
  localparam int CTRL_SEQ_BIT  = 0;
  localparam int IRQ_UNDER_BIT = 0;
  localparam int IRQ_OVER_BIT  = 1;
  localparam logic [3:0] CHID_CH0 = 4'h0;
  localparam logic [3:0] CHID_CH1 = 4'h1;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic [HYS_W-1:0] RST_HYS      = 6'h00;
  localparam logic [CNT_W-1:0] RST_EVCNT    = 4'h0;
  localparam logic [3:0]       RST_CHID     = 4'h0;
  localparam logic [RES_W-1:0] RST_THR_LOW  = 12'h000;
  localparam logic [RES_W-1:0] RST_THR_HIGH = 12'hfff;
  localparam logic [IRQ_W-1:0] RST_IRQ_MASK = 2'h0;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] awaddr;
    logic              awvalid;
    logic [DATA_W-1:0] wdata;
    logic [3:0]        wstrb;
    logic              wvalid;
    logic              bready;
    logic [ADDR_W-1:0] araddr;
    logic              arvalid;
    logic              rready;
  } axil_req_t;

  typedef struct packed {
    logic              awready;
    logic              wready;
    logic [1:0]        bresp;
    logic              bvalid;
    logic              arready;
    logic [DATA_W-1:0] rdata;
    logic [1:0]        rresp;
    logic              rvalid;
  } axil_rsp_t;

  typedef struct packed {
    logic             valid;
    logic             chan;
    logic [RES_W-1:0] result;
  } conv_sample_t;

  typedef struct packed {
    logic [RES_W-1:0] low;
    logic [RES_W-1:0] high;
  } thresh_t;

endpackage

// ==== hw/wcmp_channel.sv ====
`timescale 1ns/1ns
module wcmp_channel
  import wcmp_pkg::*;
(
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic                   restart,
  input  wire logic                   sample_valid,
  input  wire logic [RES_W-1:0]       result,
  input  wire thresh_t                thresh,
  input  wire logic [HYS_W-1:0]       hyst,
  input  wire logic [CNT_W-1:0]       event_count,
  output logic                        under_hit,
  output logic                        over_hit
);
  logic             low_act_r,  low_act_nxt;
  logic             high_act_r, high_act_nxt;
  logic [CNT_W:0]   under_cnt_r, under_cnt_nxt;
  logic [CNT_W:0]   over_cnt_r,  over_cnt_nxt;
  logic             under_hit_r, under_hit_nxt;
  logic             over_hit_r,  over_hit_nxt;
  logic [CNT_W:0]   required;
  logic [RES_W:0]   low_rel;
  logic [RES_W:0]   res_up;

  assign required = {1'b0, event_count} + {{CNT_W{1'b0}}, 1'b1};
  assign low_rel  = {1'b0, thresh.low} + {{(RES_W+1-HYS_W){1'b0}}, hyst};
  assign res_up   = {1'b0, result} + {{(RES_W+1-HYS_W){1'b0}}, hyst};

  always_comb begin
    low_act_nxt   = low_act_r;
    high_act_nxt  = high_act_r;
    under_cnt_nxt = under_cnt_r;
    over_cnt_nxt  = over_cnt_r;
    under_hit_nxt = 1'b0;
    over_hit_nxt  = 1'b0;
    if (restart) begin
      low_act_nxt   = 1'b0;
      high_act_nxt  = 1'b0;
      under_cnt_nxt = '0;
      over_cnt_nxt  = '0;
    end else if (sample_valid) begin
      // Once active, low side releases only above low plus hysteresis, high side only below high minus hysteresis
      low_act_nxt  = low_act_r ? ({1'b0, result} <= low_rel) : (result <= thresh.low);
      high_act_nxt = high_act_r ? (res_up >= {1'b0, thresh.high}) : (result >= thresh.high);
      // A miss restarts the run of consecutive hits
      under_cnt_nxt = !low_act_nxt ? '0 : (under_cnt_r == required) ? under_cnt_r : under_cnt_r + 1'b1;
      over_cnt_nxt  = !high_act_nxt ? '0 : (over_cnt_r == required) ? over_cnt_r : over_cnt_r + 1'b1;
      under_hit_nxt = low_act_nxt && (under_cnt_nxt == required);
      over_hit_nxt  = high_act_nxt && (over_cnt_nxt == required);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_act_r   <= 1'b0;
      high_act_r  <= 1'b0;
      under_cnt_r <= '0;
      over_cnt_r  <= '0;
      under_hit_r <= 1'b0;
      over_hit_r  <= 1'b0;
    end else begin
      low_act_r   <= low_act_nxt;
      high_act_r  <= high_act_nxt;
      under_cnt_r <= under_cnt_nxt;
      over_cnt_r  <= over_cnt_nxt;
      under_hit_r <= under_hit_nxt;
      over_hit_r  <= over_hit_nxt;
    end
  end

  assign under_hit = under_hit_r;
  assign over_hit  = over_hit_r;

endmodule

// ==== testbench/host_model.sv ====
`timescale 1ns/1ns
module host_model (
  input  wire logic                aclk,
  input  wire logic                busy,
  input  wire wcmp_pkg::axil_rsp_t rsp,
  output wcmp_pkg::axil_req_t      req
);
  import wcmp_pkg::*;
  initial req = '0;
  // ----------------------------------------------------------------
  // Bus cycles, one at a time
  // ----------------------------------------------------------------
  task automatic wr(input logic [IDX_W-1:0] idx, input logic [31:0] d, output logic [1:0] resp);
    @(posedge aclk);
    while (busy) @(posedge aclk); // Write only when idle
    req <= '{{idx, 2'b00}, 1'b1, d, 4'hf, 1'b1, 1'b1, '0, 1'b0, 1'b0};
    do begin
      @(posedge aclk);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end while (!rsp.bvalid);
    resp = rsp.bresp;
    req.bready <= 1'b0;
  endtask
  task automatic rd(input logic [IDX_W-1:0] idx, output logic [31:0] d, output logic [1:0] resp);
    @(posedge aclk);
    req <= '{'0, 1'b0, '0, 4'h0, 1'b0, 1'b0, {idx, 2'b00}, 1'b1, 1'b1};
    do begin
      @(posedge aclk);
      if (rsp.arready) req.arvalid <= 1'b0;
    end while (!rsp.rvalid);
    d = rsp.rdata;
    resp = rsp.rresp;
    req.rready <= 1'b0;
  endtask
endmodule

// ==== testbench/tb.sv ====
`timescale 1ns/1ns
module tb;
  import wcmp_pkg::*;
  logic         aclk, aresetn, busy, gc_reset, alert, seq_go_pulse, irq;
  axil_req_t    req;
  axil_rsp_t    rsp;
  conv_sample_t conv;
  int           num_errors, n_checks;
  int           n_go;
  window_comparator_alert_status i_window_comparator_alert_status (.aclk(aclk), .aresetn(aresetn),
    .axil_req(req), .axil_rsp(rsp), .conv(conv), .busy(busy), .gc_reset(gc_reset), .alert(alert),
    .seq_go_pulse(seq_go_pulse), .irq(irq));
  host_model i_host (.aclk(aclk), .busy(busy), .rsp(rsp), .req(req));
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // Pulse lasts one cycle, so it is counted rather than looked at
  always @(posedge aclk) begin
    if (seq_go_pulse === 1'b1) begin
      n_go <= n_go + 1;
    end
  end
  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk(input logic [IDX_W-1:0] idx, input logic [31:0] exp, input logic [1:0] rexp = RESP_OKAY);
    logic [31:0] d;
    logic [1:0]  r;
    i_host.rd(idx, d, r);
    cmp(d, exp);
    cmp(r, rexp);
  endtask
  task automatic put(input logic [IDX_W-1:0] idx, input logic [31:0] d);
    logic [1:0] r;
    i_host.wr(idx, d, r);
    cmp(r, RESP_OKAY);
  endtask
  // Back-to-back samples, then idle long enough for alert to land
  task automatic samp(input logic ch, input logic [RES_W-1:0] res, input int n);
    repeat (n) begin
      @(posedge aclk);
      conv <= '{1'b1, ch, res};
    end
    @(posedge aclk);
    conv.valid <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    chk(IDX_HYS1, 32'h0);
    chk(IDX_EVCNT, 32'h0);
    chk(IDX_FIRST_CHAN, 32'h0);
    chk(IDX_UNDER, 32'h0);
    chk(IDX_OVER, 32'h0);
    chk(7'h7f, 32'h0, RESP_SLVERR);
    busy <= 1'b1;
    chk(IDX_STATUS, 32'h1);
    busy <= 1'b0;
    chk(IDX_STATUS, 32'h0);
  endtask
  task automatic t_fields;
    put(IDX_HYS1, 32'hffffffff);
    chk(IDX_HYS1, 32'h3f);
    put(IDX_EVCNT, 32'hff);
    chk(IDX_EVCNT, 32'hf0);
    put(IDX_FIRST_CHAN, 32'hff);
    chk(IDX_FIRST_CHAN, 32'h0);
    put(IDX_HYS1, 32'h0);
    put(IDX_EVCNT, 32'h20);
    put(IDX_IRQ_MASK, 32'h3);
  endtask
  task automatic t_count;
    put(IDX_THR1, 32'h0fff0100);
    put(IDX_THR0, 32'h08000000);
    samp(1'b1, 12'h100, 2);
    samp(1'b1, 12'h101, 1);
    samp(1'b1, 12'h100, 2);
    cmp(alert, 1'b0);
    samp(1'b1, 12'h100, 1);
    cmp(alert, 1'b1);
    chk(IDX_UNDER, 32'h2);
    chk(IDX_FIRST_CHAN, 32'h10);
    cmp(irq, 1'b1);
    chk(IDX_IRQ_STAT, 32'h1);
    repeat (2) @(posedge aclk);
    cmp(irq, 1'b0);
  endtask
  task automatic t_over;
    put(IDX_IRQ_MASK, 32'h1);
    samp(1'b0, 12'h800, 3);
    chk(IDX_OVER, 32'h1);
    cmp(irq, 1'b0);
    chk(IDX_FIRST_CHAN, 32'h10);
    chk(IDX_IRQ_STAT, 32'h2);
  endtask
  task automatic t_clear;
    @(posedge aclk);
    gc_reset <= 1'b1;
    @(posedge aclk);
    gc_reset <= 1'b0;
    chk(IDX_UNDER, 32'h0);
    chk(IDX_OVER, 32'h0);
    chk(IDX_FIRST_CHAN, 32'h0);
    cmp(alert, 1'b0);
    samp(1'b1, 12'h000, 3);
    samp(1'b0, 12'hfff, 3);
    put(IDX_UNDER, 32'h0);
    chk(IDX_UNDER, 32'h2);
    put(IDX_OVER, 32'hff);
    chk(IDX_OVER, 32'h0);
    put(IDX_UNDER, 32'h2);
    chk(IDX_UNDER, 32'h0);
    cmp(alert, 1'b0);
    chk(IDX_FIRST_CHAN, 32'h10);
    put(IDX_CTRL, 32'h1);
    chk(IDX_FIRST_CHAN, 32'h0);
    cmp(n_go, 32'h1);
  endtask
  // Channel 1 under side is active with its count full on entry
  task automatic t_hyst;
    put(IDX_HYS1, 32'h4);
    samp(1'b1, 12'h104, 1);
    chk(IDX_UNDER, 32'h2);
    samp(1'b1, 12'h105, 1);
    put(IDX_UNDER, 32'h2);
    samp(1'b1, 12'h104, 3);
    chk(IDX_UNDER, 32'h0);
  endtask
  task automatic results;
    $display("checks=%0d errors=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #100000;
    num_errors++;
    results;
  end
  initial begin
    aresetn = 1'b0;
    busy = 1'b0;
    gc_reset = 1'b0;
    conv = '0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_reset;
    t_fields;
    t_count;
    t_over;
    t_clear;
    t_hyst;
    results;
  end
endmodule
